// *** design/hcbg_top.v ***
/*
 * Horizontal clamp, preblank and blanking generator with its 3-wire
 * serial configuration port and per-sequence pattern store.
 * Assumes pix_cnt, line_cnt and vertical_sequence_sel come from the field counters
 * on ref_clk, advanced by the one-cycle pix_en enable; the serial
 * pins are asynchronous and are synchronised here.
 */
`timescale 1ns/1ps
`include "hcbg_defines.vh"

module hcbg_top (
  ref_clk,       // 40 MHz system clock
  rst_n,         // synchronous reset, active low
  pix_en,        // pixel advance enable
  pix_cnt,       // pixel position within line
  line_cnt,      // line position within field
  vertical_sequence_sel,      // sequence of current field region
  hclk_one_in,   // phase one from timing core
  hclk_three_in, // phase three from timing core
  last_hclk_in,  // last h-clock from timing core
  ser_load_n,    // serial frame select, active low
  ser_clk,       // serial clock
  ser_data,      // serial data in
  black_level_clamp_pulse_n,    // clamp output, active low
  preblank_pulse_n,             // preblank output, active low
  horizontal_blanking,          // blanking active, high
  horizontal_clock_phase_one,   // gated phase one
  horizontal_clock_phase_two,   // gated phase two
  horizontal_clock_phase_three, // gated phase three
  horizontal_clock_phase_four,  // gated phase four
  last_horizontal_clock         // gated last h-clock
);
  input  wire        ref_clk;       // clock
  input  wire        rst_n;         // reset
  input  wire        pix_en;        // pixel enable
  input  wire [12:0] pix_cnt;       // pixel counter
  input  wire [11:0] line_cnt;      // line counter
  input  wire [1:0]  vertical_sequence_sel;      // sequence select
  input  wire        hclk_one_in;   // core phase one
  input  wire        hclk_three_in; // core phase three
  input  wire        last_hclk_in;  // core last clock
  input  wire        ser_load_n;    // serial select
  input  wire        ser_clk;       // serial clock
  input  wire        ser_data;      // serial data
  output reg         black_level_clamp_pulse_n;    // clamp
  output reg         preblank_pulse_n;             // preblank
  output reg         horizontal_blanking;          // blanking
  output reg         horizontal_clock_phase_one;   // h1
  output reg         horizontal_clock_phase_two;   // h2
  output reg         horizontal_clock_phase_three; // h3
  output reg         horizontal_clock_phase_four;  // h4
  output reg         last_horizontal_clock;        // hl

  //////////////////////////////////////////////////////////////////////
  // serial port: synchronise pins, shift frames, strobe a write
  //////////////////////////////////////////////////////////////////////
  reg  [2:0]  pin_meta_reg;  // first stage, read only by second
  reg  [2:0]  pin_sync_reg;  // {data, clk, load_n} synchronised
  reg         sck_prev_reg;  // for rising-edge detect
  reg  [4:0]  bit_cnt_reg;   // bits taken in this frame
  reg  [22:0] shift_reg;     // partial frame
  reg  [23:0] frame_reg;     // completed frame
  reg         wr_reg;        // one-cycle write strobe

  wire sck_rise = pin_sync_reg[1] & ~sck_prev_reg; // serial edge
  wire sel_act  = ~pin_sync_reg[0];                // frame open

  // sampling rate caps the serial clock at well under ref_clk / 4
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_meta_reg <= 3'h1;
      pin_sync_reg <= 3'h1;
      sck_prev_reg <= 1'b0;
      bit_cnt_reg  <= 5'h00;
      shift_reg    <= 23'h000000;
      frame_reg    <= 24'h000000;
      wr_reg       <= 1'b0;
    end else begin
      pin_meta_reg <= {ser_data, ser_clk, ser_load_n};
      pin_sync_reg <= pin_meta_reg;
      sck_prev_reg <= pin_sync_reg[1];
      wr_reg       <= 1'b0;
      if (!sel_act) begin // frame closed: restart count
        bit_cnt_reg <= 5'h00;
      end else if (sck_rise && bit_cnt_reg != `HCBG_FRAME_BITS) begin
        shift_reg   <= {shift_reg[21:0], pin_sync_reg[2]};
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
        if (bit_cnt_reg == `HCBG_FRAME_LAST) begin // last bit in
          frame_reg <= {shift_reg, pin_sync_reg[2]};
          wr_reg    <= 1'b1;
        end
      end
    end
  end

  wire [7:0]  wr_addr = frame_reg[23:16]; // register address
  wire [15:0] wr_data = frame_reg[15:0];  // register data

  //////////////////////////////////////////////////////////////////////
  // configuration store: per-sequence words and global line masks
  //////////////////////////////////////////////////////////////////////
  reg [12:0] cfg_mem  [0:127];                   // {seq, idx}
  reg [11:0] mask_mem [0:`HCBG_MASK_WORDS-1];    // area*4+kind
  integer    i;                                  // reset loop index

  // toggles reset parked at 8191 so nothing moves before programming
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      for (i = 0; i < 128; i = i + 1) begin
        if (i % 32 == 0) begin
          cfg_mem[i] <= `HCBG_CTRL_RST;
        end else begin
          cfg_mem[i] <= `HCBG_TOG_NONE;
        end
      end
      for (i = 0; i < `HCBG_MASK_WORDS; i = i + 1) begin
        mask_mem[i] <= `HCBG_MASK_RST;
      end
    end else if (wr_reg) begin
      if (!wr_addr[7]) begin // per-sequence word
        cfg_mem[wr_addr[6:0]] <= wr_data[12:0];
      end else if (wr_addr[6:4] == 3'h0 &&
                   wr_addr[3:0] < 4'hC) begin // global mask word
        mask_mem[wr_addr[3:0]] <= wr_data[11:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // line-start snapshot: sequence, parity and mask decisions
  //////////////////////////////////////////////////////////////////////
  wire        line_start = pix_en && (pix_cnt == 13'h0000);
  reg  [1:0]  seq_l_reg;      // sequence for this line
  reg         odd_l_reg;      // line parity for this line
  reg         clp_mask_l_reg; // clamp suppressed this line
  reg         pb_mask_l_reg;  // preblank suppressed this line
  wire [2:0]  clp_in_area;    // line inside clamp area
  wire [2:0]  pb_in_area;     // line inside preblank area

  genvar a;
  generate
    for (a = 0; a < 3; a = a + 1) begin : g_area
      wire [11:0] cf = mask_mem[a*4 + 0];
      wire [11:0] cl = mask_mem[a*4 + 1];
      wire [11:0] pf = mask_mem[a*4 + 2];
      wire [11:0] pl = mask_mem[a*4 + 3];
      // inclusive window, area off when parked at 0xFFF
      assign clp_in_area[a] = (cf != `HCBG_MASK_RST) &&
                              (cl != `HCBG_MASK_RST) &&
                              (line_cnt >= cf) && (line_cnt <= cl);
      assign pb_in_area[a]  = (pf != `HCBG_MASK_RST) &&
                              (pl != `HCBG_MASK_RST) &&
                              (line_cnt >= pf) && (line_cnt <= pl);
    end
  endgenerate

  // masks and parity settle once, before any toggle of the line
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      seq_l_reg      <= 2'h0;
      odd_l_reg      <= 1'b0;
      clp_mask_l_reg <= 1'b0;
      pb_mask_l_reg  <= 1'b0;
    end else if (line_start) begin
      seq_l_reg      <= vertical_sequence_sel;
      odd_l_reg      <= line_cnt[0];
      clp_mask_l_reg <= |clp_in_area;
      pb_mask_l_reg  <= |pb_in_area;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // per-line pattern words of the active sequence
  //////////////////////////////////////////////////////////////////////
  wire [12:0] ctrl_now = cfg_mem[{vertical_sequence_sel,  `HCBG_IDX_CTRL}];
  wire [12:0] ctrl_l   = cfg_mem[{seq_l_reg, `HCBG_IDX_CTRL}];
  wire [12:0] clp_t1   = cfg_mem[{seq_l_reg, `HCBG_IDX_CLP_T1}];
  wire [12:0] clp_t2   = cfg_mem[{seq_l_reg, `HCBG_IDX_CLP_T2}];
  wire [12:0] pb_t1    = cfg_mem[{seq_l_reg, `HCBG_IDX_PB_T1}];
  wire [12:0] pb_t2    = cfg_mem[{seq_l_reg, `HCBG_IDX_PB_T2}];
  wire [12:0] rep_len  = cfg_mem[{seq_l_reg, `HCBG_IDX_LEN}];
  wire [7:0]  rep_cnt  = cfg_mem[{seq_l_reg, `HCBG_IDX_REP}]
                         [7:0];
  wire [2:0]  alt_mode = ctrl_l[`HCBG_CTRL_ALT_MSB:`HCBG_CTRL_ALT_LSB];
  wire        blk_lvl  = ctrl_l[`HCBG_CTRL_BLK_LVL];

  // a position of 8191 never fires, so parked toggles stay silent
  function hit;
    input [12:0] pos;
    input [12:0] tog;
    begin
      hit = (pos == tog) && (tog != `HCBG_TOG_NONE);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  // blanking toggle slots: mode decides which set fires on a line
  //////////////////////////////////////////////////////////////////////
  wire [12:0] even_tog [0:5]; // even-set positions
  wire [5:0]  slot_hit;       // direct-mode toggles firing now
  wire [3:0]  rpt_hit;        // repeat-mode offsets matching
  reg  [12:0] off_cnt_reg;    // offset inside repeat pattern

  genvar s;
  generate
    for (s = 0; s < 6; s = s + 1) begin : g_slot
      localparam integer IE = `HCBG_IDX_EVEN1 + s;
      localparam integer IO = `HCBG_IDX_ODD1 + s;
      wire [12:0] te = cfg_mem[{seq_l_reg, IE[4:0]}];
      wire [12:0] to = cfg_mem[{seq_l_reg, IO[4:0]}];
      reg         en;
      assign even_tog[s] = te;
      always @* begin
        case (alt_mode)
          `HCBG_ALT_NONE:   en = 1'b1;
          `HCBG_ALT_ODD12:  en = (s < 2) ? odd_l_reg
                                         : ~odd_l_reg;
          `HCBG_ALT_EVEN12: en = (s < 2) ? ~odd_l_reg
                                         : odd_l_reg;
          `HCBG_ALT_ODDSET: en = 1'b1;
          default:          en = 1'b0; // repeat modes use rpt_hit
        endcase
      end
      // odd lines in mode 3 take the odd set in place of the even
      assign slot_hit[s] = en && hit(pix_cnt,
        (alt_mode == `HCBG_ALT_ODDSET && odd_l_reg) ? to : te);
      if (s < 4) begin : g_rpt
        assign rpt_hit[s] = (off_cnt_reg == te) &&
                            (te != `HCBG_TOG_NONE);
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////
  // pulse state machines: next values
  //////////////////////////////////////////////////////////////////////
  reg        clp_lvl_reg;   // clamp level before masking
  reg        pb_lvl_reg;    // preblank level before masking
  reg        blk_reg;       // blanking active
  reg        in_rpt_reg;    // inside repeat window
  reg  [7:0] rep_left_reg;  // patterns still to play
  reg        clp_lvl_next;  // next clamp level
  reg        pb_lvl_next;   // next preblank level
  reg        blk_next;      // next blanking
  reg        in_rpt_next;   // next repeat-window flag
  reg  [7:0] rep_left_next; // next repeat count
  reg [12:0] off_cnt_next;  // next pattern offset
  reg        clp_mask_now;  // mask seen by this cycle's output
  reg        pb_mask_now;   // mask seen by this cycle's output

  wire rpt_mode = alt_mode[2]; // modes 4 to 7

  always @* begin
    clp_lvl_next  = clp_lvl_reg;
    pb_lvl_next   = pb_lvl_reg;
    blk_next      = blk_reg;
    in_rpt_next   = in_rpt_reg;
    rep_left_next = rep_left_reg;
    off_cnt_next  = off_cnt_reg;
    clp_mask_now  = clp_mask_l_reg;
    pb_mask_now   = pb_mask_l_reg;
    if (line_start) begin // new line: start levels of new sequence
      clp_lvl_next = ctrl_now[`HCBG_CTRL_CLP_LVL];
      pb_lvl_next  = ctrl_now[`HCBG_CTRL_PB_LVL];
      blk_next     = 1'b0;
      in_rpt_next  = 1'b0;
      clp_mask_now = |clp_in_area;
      pb_mask_now  = |pb_in_area;
    end else if (pix_en) begin
      // two toggles on one pixel cancel, as two flips would
      clp_lvl_next = clp_lvl_reg ^ hit(pix_cnt, clp_t1)
                                 ^ hit(pix_cnt, clp_t2);
      pb_lvl_next  = pb_lvl_reg ^ hit(pix_cnt, pb_t1)
                                ^ hit(pix_cnt, pb_t2);
      if (!rpt_mode) begin
        blk_next = blk_reg ^ (^slot_hit);
      end else if (hit(pix_cnt, even_tog[4])) begin // window opens
        blk_next      = 1'b1;
        in_rpt_next   = 1'b1;
        rep_left_next = rep_cnt;
        off_cnt_next  = (rep_len <= 13'h0001) ? 13'h0000 : 13'h0001;
      end else if (hit(pix_cnt, even_tog[5])) begin // window closes
        blk_next    = 1'b0;
        in_rpt_next = 1'b0;
      end else if (in_rpt_reg && rep_left_reg != 8'h00) begin
        blk_next = blk_reg ^ (^rpt_hit);
        if (off_cnt_reg + 13'h0001 >= rep_len) begin // pattern wraps
          off_cnt_next  = 13'h0000;
          rep_left_next = rep_left_reg - 8'h01;
        end else begin
          off_cnt_next = off_cnt_reg + 13'h0001;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // state and output registers
  //////////////////////////////////////////////////////////////////////
  // outputs idle inactive: clamp and preblank high, no blanking
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      clp_lvl_reg                  <= 1'b1;
      pb_lvl_reg                   <= 1'b1;
      blk_reg                      <= 1'b0;
      in_rpt_reg                   <= 1'b0;
      rep_left_reg                 <= 8'h00;
      off_cnt_reg                  <= 13'h0000;
      black_level_clamp_pulse_n    <= 1'b1;
      preblank_pulse_n             <= 1'b1;
      horizontal_blanking          <= 1'b0;
      horizontal_clock_phase_one   <= 1'b0;
      horizontal_clock_phase_two   <= 1'b1;
      horizontal_clock_phase_three <= 1'b0;
      horizontal_clock_phase_four  <= 1'b1;
      last_horizontal_clock        <= 1'b0;
    end else begin
      clp_lvl_reg  <= clp_lvl_next;
      pb_lvl_reg   <= pb_lvl_next;
      blk_reg      <= blk_next;
      in_rpt_reg   <= in_rpt_next;
      rep_left_reg <= rep_left_next;
      off_cnt_reg  <= off_cnt_next;
      // masked lines hold the pulse at its inactive high level
      black_level_clamp_pulse_n <= clp_mask_now | clp_lvl_next;
      preblank_pulse_n          <= pb_mask_now | pb_lvl_next;
      horizontal_blanking       <= blk_next;
      // phases two and four stay the inverses of one and three
      if (blk_next) begin
        horizontal_clock_phase_one   <= blk_lvl;
        horizontal_clock_phase_two   <= ~blk_lvl;
        horizontal_clock_phase_three <= blk_lvl;
        horizontal_clock_phase_four  <= ~blk_lvl;
        last_horizontal_clock        <= blk_lvl;
      end else begin
        horizontal_clock_phase_one   <= hclk_one_in;
        horizontal_clock_phase_two   <= ~hclk_one_in;
        horizontal_clock_phase_three <= hclk_three_in;
        horizontal_clock_phase_four  <= ~hclk_three_in;
        last_horizontal_clock        <= last_hclk_in;
      end
    end
  end

endmodule // hcbg_top

// *** inc/hcbg_defines.vh ***
/*
 * Constants for the horizontal clamp and blanking generator: the serial
 * frame layout, the configuration word map, field positions within the
 * control word, and the reset values.
 * Assumes one include per compile unit; the guard covers repeats.
 */
`ifndef HCBG_DEFINES_VH
`define HCBG_DEFINES_VH

// vertical sequences held in the pattern store
`define HCBG_NSEQ        4
`define HCBG_SEQ_W       2

// serial frame: 8 address bits then 16 data bits, msb first
`define HCBG_FRAME_BITS  5'h18
`define HCBG_FRAME_LAST  5'h17

// per-sequence word index (address bits [4:0], sequence in [6:5])
`define HCBG_IDX_CTRL    5'h00
`define HCBG_IDX_CLP_T1  5'h01
`define HCBG_IDX_CLP_T2  5'h02
`define HCBG_IDX_PB_T1   5'h03
`define HCBG_IDX_PB_T2   5'h04
`define HCBG_IDX_EVEN1   5'h05
`define HCBG_IDX_LEN     5'h0B
`define HCBG_IDX_REP     5'h0C
`define HCBG_IDX_ODD1    5'h0D

// control word fields
`define HCBG_CTRL_CLP_LVL 0
`define HCBG_CTRL_PB_LVL  1
`define HCBG_CTRL_BLK_LVL 2
`define HCBG_CTRL_ALT_LSB 4
`define HCBG_CTRL_ALT_MSB 6

// global line-mask words: base + area*4 + kind
`define HCBG_MASK_BASE   8'h80
`define HCBG_MASK_WORDS  12
`define HCBG_MK_CLP_FIRST 2'h0
`define HCBG_MK_CLP_LAST  2'h1
`define HCBG_MK_PB_FIRST  2'h2
`define HCBG_MK_PB_LAST   2'h3

// reset values
`define HCBG_TOG_NONE    13'h1FFF
`define HCBG_CTRL_RST    13'h0000
`define HCBG_MASK_RST    12'hFFF

// alternation modes
`define HCBG_ALT_NONE    3'h0
`define HCBG_ALT_ODD12   3'h1
`define HCBG_ALT_EVEN12  3'h2
`define HCBG_ALT_ODDSET  3'h3

`endif

// *** test/hcbg_checker.sv ***
/*
 * port-level assertions for the clamp, preblank and blanking generator.
 * assumes it is bound to every hcbg_top instance by the bind below.
 */
`timescale 1ns/1ps
module hcbg_checker (
  input wire        ref_clk,       // clock
  input wire        rst_n,         // sync reset, active low
  input wire        pix_en,        // pixel advance
  input wire [12:0] pix_cnt,       // pixel in line
  input wire        hclk_one_in,   // core phase one
  input wire        hclk_three_in, // core phase three
  input wire        last_hclk_in,  // core last clock
  input wire        black_level_clamp_pulse_n,    // clamp
  input wire        preblank_pulse_n,             // preblank
  input wire        horizontal_blanking,          // blanking
  input wire        horizontal_clock_phase_one,   // h1
  input wire        horizontal_clock_phase_two,   // h2
  input wire        horizontal_clock_phase_three, // h3
  input wire        horizontal_clock_phase_four,  // h4
  input wire        last_horizontal_clock         // hl
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  // blanking windows; three open cycles cover either gating alignment
  sequence s_open;
    (!horizontal_blanking)[*3];
  endsequence
  sequence s_shut;
    horizontal_blanking[*2];
  endsequence
  ////////////////////////////////////////////////////////////////////////
  // reset drives every pulse inactive
  property p_reset_idle;
    disable iff (1'b0)
    !rst_n |=> black_level_clamp_pulse_n && preblank_pulse_n &&
      !horizontal_blanking && !horizontal_clock_phase_one &&
      horizontal_clock_phase_two;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("outputs not idle after reset");
  // phase two always opposes phase one
  property p_two_inverse;
    horizontal_clock_phase_two == !horizontal_clock_phase_one;
  endproperty
  a_two_inverse: assert property (p_two_inverse)
    else $error("phase two not inverse of phase one");
  property p_four_inverse;
    horizontal_clock_phase_four == !horizontal_clock_phase_three;
  endproperty
  a_four_inverse: assert property (p_four_inverse)
    else $error("phase four not inverse of phase three");
  // inside blanking phase one, phase three and the last clock share one level
  property p_blank_forced;
    s_shut |-> horizontal_clock_phase_one == horizontal_clock_phase_three
      && horizontal_clock_phase_three == last_horizontal_clock;
  endproperty
  a_blank_forced: assert property (p_blank_forced)
    else $error("clocks not forced together in blanking");
  // outside blanking the core clocks pass with one cycle delay
  property p_open_one;
    s_open |-> horizontal_clock_phase_one == $past(hclk_one_in);
  endproperty
  a_open_one: assert property (p_open_one)
    else $error("phase one not following core");
  property p_open_three;
    s_open |-> horizontal_clock_phase_three == $past(hclk_three_in);
  endproperty
  a_open_three: assert property (p_open_three)
    else $error("phase three not following core");
  property p_open_last;
    s_open |-> last_horizontal_clock == $past(last_hclk_in);
  endproperty
  a_open_last: assert property (p_open_last)
    else $error("last clock not following core");
  // no pixel, no change on the pulse outputs
  property p_hold;
    !pix_en |=> $stable(black_level_clamp_pulse_n) &&
      $stable(preblank_pulse_n) && $stable(horizontal_blanking);
  endproperty
  a_hold: assert property (p_hold)
    else $error("pulse changed without a pixel");
  // every line opens outside blanking
  property p_line_idle;
    pix_en && pix_cnt == 13'h0000 |=> !horizontal_blanking;
  endproperty
  a_line_idle: assert property (p_line_idle)
    else $error("blanking active at line start");
endmodule // hcbg_checker
bind hcbg_top hcbg_checker u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .pix_en(pix_en), .pix_cnt(pix_cnt),
  .hclk_one_in(hclk_one_in), .hclk_three_in(hclk_three_in),
  .last_hclk_in(last_hclk_in),
  .black_level_clamp_pulse_n(black_level_clamp_pulse_n),
  .preblank_pulse_n(preblank_pulse_n),
  .horizontal_blanking(horizontal_blanking),
  .horizontal_clock_phase_one(horizontal_clock_phase_one),
  .horizontal_clock_phase_two(horizontal_clock_phase_two),
  .horizontal_clock_phase_three(horizontal_clock_phase_three),
  .horizontal_clock_phase_four(horizontal_clock_phase_four),
  .last_horizontal_clock(last_horizontal_clock));

// *** test/hcbg_afe_model.sv ***
/*
 * front end stand-in: counts clamp pulses it receives.
 * assumes the generator's clock and reset.
 */
`timescale 1ns/1ps
module hcbg_afe_model (
  input  wire        ref_clk,      // clock
  input  wire        rst_n,        // sync reset
  input  wire        clamp_n,      // clamp, active low
  output reg  [15:0] clamp_pulses  // falling edges seen
);
  reg clamp_last_reg; // previous clamp level
  // a pulse starts where the clamp line falls
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      clamp_pulses   <= 16'h0000;
      clamp_last_reg <= 1'b1;
    end else begin
      if (clamp_last_reg && !clamp_n) clamp_pulses <= clamp_pulses + 1'b1;
      clamp_last_reg <= clamp_n;
    end
  end
endmodule // hcbg_afe_model

// *** test/testbench.sv ***
/*
 * testbench: serial writes and pixel lines, per-pixel prediction.
 * assumes hcbg_defines.vh on the include path.
 */
`timescale 1ns/1ps
`include "hcbg_defines.vh"
module testbench;
  localparam LINE_LEN = 64; // short lines keep the run brief
  reg         ref_clk, rst_n, pix_en, hclk_one_in;
  reg         ser_load_n, ser_clk, ser_data;
  reg  [12:0] pix_cnt;
  reg  [11:0] line_cnt;
  reg  [1:0]  vertical_sequence_sel;
  wire        clamp_n, pb_n, blank, ph1, ph2, ph3, ph4, phl;
  wire [15:0] clamp_pulses;
  reg  [12:0] word [0:127]; // mirror of sequence words
  reg  [11:0] mask [0:11];  // mirror of mask words
  reg         last_c;       // predicted clamp, previous pixel
  integer     failures, compares, cycles, n_fall, i;
  ////////////////////////////////////////////////////////////////////////
  hcbg_top dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .pix_en(pix_en), .pix_cnt(pix_cnt),
    .line_cnt(line_cnt), .vertical_sequence_sel(vertical_sequence_sel), .hclk_one_in(hclk_one_in),
    .hclk_three_in(!hclk_one_in), .last_hclk_in(hclk_one_in),
    .ser_load_n(ser_load_n), .ser_clk(ser_clk), .ser_data(ser_data),
    .black_level_clamp_pulse_n(clamp_n), .preblank_pulse_n(pb_n),
    .horizontal_blanking(blank), .horizontal_clock_phase_one(ph1),
    .horizontal_clock_phase_two(ph2), .horizontal_clock_phase_three(ph3),
    .horizontal_clock_phase_four(ph4), .last_horizontal_clock(phl));
  hcbg_afe_model afe (
    .ref_clk(ref_clk), .rst_n(rst_n), .clamp_n(clamp_n),
    .clamp_pulses(clamp_pulses));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = !ref_clk;
  end
  // core phase toggles every cycle
  always @(posedge ref_clk) begin
    #1 hclk_one_in = !hclk_one_in;
  end
  // hang guard
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      summarize;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task summarize;
    begin
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge ref_clk);
      #1;
    end
  endtask
  // one 24-bit frame, msb first
  task wr(input [7:0] a, input [15:0] d);
    reg [23:0] f;
    integer    k;
    begin
      f = {a, d};
      ser_load_n = 1'b0;
      for (k = 23; k >= 0; k = k - 1) begin
        ser_data = f[k];
        tick(4);
        ser_clk = 1'b1;
        tick(4);
        ser_clk = 1'b0;
      end
      tick(4);
      ser_load_n = 1'b1;
      tick(10);
      if (a < 8'h80) word[a[6:0]] = d[12:0];
      else if (a < 8'h8C) mask[a - 8'h80] = d[11:0];
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  function hit(input [12:0] p, input [12:0] t); // parked toggles silent
    hit = (p == t) && t != 13'h0000 && t != 13'h1FFF;
  endfunction
  function inside_area(input [11:0] ln, input [11:0] f, input [11:0] l);
    inside_area = f != 12'hFFF && l != 12'hFFF && ln >= f && ln <= l;
  endfunction
  // blanking toggles a line uses
  function used(input [2:0] m, input odd, input integer k);
    case (m)
      3'h0: used = k < 6;
      3'h1: used = (k < 2) ? odd : (k < 6 && !odd);
      3'h2: used = (k < 2) ? !odd : (k < 6 && odd);
      3'h3: used = odd ? k >= 6 : k < 6;
      default: used = k == 4 || k == 5; // repeat modes: start, end
    endcase
  endfunction
  // one line; line and sequence scrambled after pixel zero
  task line(input [11:0] ln, input [1:0] sq);
    integer p, k, b0;
    reg     c, pb, b, pbk, cm, pm;
    begin
      b0 = sq * 32;
      cm = 1'b0;
      pm = 1'b0;
      b  = 1'b0;
      for (k = 0; k < 3; k = k + 1) begin
        cm = cm | inside_area(ln, mask[4*k], mask[4*k+1]);
        pm = pm | inside_area(ln, mask[4*k+2], mask[4*k+3]);
      end
      for (p = 0; p < LINE_LEN; p = p + 1) begin
        pix_en   = 1'b1;
        pix_cnt  = 13'(p);
        line_cnt = (p == 0) ? ln : ~ln;
        vertical_sequence_sel = (p == 0) ? sq : ~sq;
        tick(1);
        pbk = b;
        if (p == 0) begin
          c  = word[b0][0];
          pb = word[b0][1];
          b  = 1'b0;
        end else begin
          c  = c ^ hit(13'(p), word[b0+1]) ^ hit(13'(p), word[b0+2]);
          pb = pb ^ hit(13'(p), word[b0+3]) ^ hit(13'(p), word[b0+4]);
          for (k = 0; k < 12; k = k + 1)
            if (used(word[b0][6:4], ln[0], k))
              b = b ^ hit(13'(p), word[b0 + 5 + k + (k > 5 ? 2 : 0)]);
          if (word[b0][6] && p > word[b0+9] &&
              p - word[b0+9] < word[b0+11] * word[b0+12][7:0])
            for (k = 0; k < 4; k = k + 1)
              if ((p - word[b0+9]) % word[b0+11] == word[b0+5+k]) b = !b;
        end
        chk(clamp_n, cm | c);
        chk(pb_n, pm | pb);
        chk(blank, b);
        if (b && pbk) chk(ph1, word[b0][2]);
        if (last_c && !(cm | c)) n_fall = n_fall + 1;
        last_c = cm | c;
      end
      pix_en = 1'b0;
      tick(2);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0; pix_en = 1'b0; pix_cnt = 13'h0000; line_cnt = 12'h000;
    vertical_sequence_sel = 2'h0; hclk_one_in = 1'b0; ser_load_n = 1'b1;
    ser_clk = 1'b0; ser_data = 1'b0; failures = 0; compares = 0;
    cycles = 0; n_fall = 0; last_c = 1'b1;
    for (i = 0; i < 128; i = i + 1)
      word[i] = (i % 32 == 0) ? 13'h0000 : 13'h1FFF;
    for (i = 0; i < 12; i = i + 1) mask[i] = 12'hFFF;
    tick(16);
    rst_n = 1'b1;
    tick(3);
    line(12'h001, 2'h0);
    // seq 0: clamp 10-20, preblank 5-30, blank 40-50 at high level
    wr(8'h00, 16'h0007); wr(8'h01, 16'h000A); wr(8'h02, 16'h0014);
    wr(8'h03, 16'h0005); wr(8'h04, 16'h001E);
    wr(8'h05, 16'h0028); wr(8'h06, 16'h0032);
    // seq 1: equal clamp toggles, one parked preblank toggle
    wr(8'h21, 16'h0008); wr(8'h22, 16'h0008);
    wr(8'h23, 16'h000C); wr(8'h24, 16'h1FFF);
    for (i = 0; i < 6; i = i + 1) begin
      wr(8'(8'h25 + i), 16'(4 + 9 * i));
      wr(8'(8'h2D + i), 16'(6 + 9 * i));
    end
    line(12'h002, 2'h0); line(12'h002, 2'h1); line(12'h003, 2'h0);
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'h20, 16'(i * 16));
      line(12'h006, 2'h1); line(12'h007, 2'h1);
    end
    // clamp area 10-12, preblank 11, unmapped write
    wr(8'h84, 16'h000A); wr(8'h85, 16'h000C);
    wr(8'h8A, 16'h000B); wr(8'h8B, 16'h000B); wr(8'h90, 16'h0001);
    for (i = 9; i < 14; i = i + 1) line(12'(i), 2'h0);
    wr(8'h84, 16'h0FFF); line(12'h00B, 2'h0);
    // seq 2: repeat mode, start 15, end 35, one repeat
    wr(8'h40, 16'h0044); wr(8'h49, 16'h000F); wr(8'h4A, 16'h0023);
    wr(8'h45, 16'h0001); wr(8'h46, 16'h0003);
    wr(8'h4B, 16'h0004); wr(8'h4C, 16'h0001); line(12'h008, 2'h2);
    chk(clamp_pulses, 16'(n_fall));
    summarize;
  end
endmodule // testbench
